// [pkg/dewc_pkg.sv]
// Constants, types and carriers for the data EEPROM write controller.
// Assumes one 10 MHz core clock and a synchronous active-high reset.
package dewc_pkg;
   //------------------------------------------------------------
   // Register offsets
   //------------------------------------------------------------
   localparam logic [7:0] REG_IRQ_CTRL  = 8'h0B;
   localparam logic [7:0] REG_PERI_FLAG = 8'h0C;
   localparam logic [7:0] REG_PERI_IEN  = 8'h8C;
   localparam logic [7:0] REG_BYTE_BUF  = 8'h9A;
   localparam logic [7:0] REG_LOC_SEL   = 8'h9B;
   localparam logic [7:0] REG_NVM_CTRL  = 8'h9C;
   localparam logic [7:0] REG_UNLOCK    = 8'h9D;
   //------------------------------------------------------------
   // Field positions and values
   //------------------------------------------------------------
   localparam int         CTL_ABORT_BIT  = 3;
   localparam int         CTL_PERMIT_BIT = 2;
   localparam int         CTL_GO_BIT     = 1;
   localparam int         CTL_RD_BIT     = 0;
   localparam int         FLAG_DONE_BIT  = 7;
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [7:0] ERASED_BYTE    = 8'hFF;
   localparam logic [7:0] UNLOCK_KEY1    = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2    = 8'hAA;
   localparam int         MEM_DEPTH      = 256;
   //------------------------------------------------------------
   // Timing: cycles between sequence steps, timers
   //------------------------------------------------------------
   localparam logic [1:0]  SEQ_GAP_KEY    = 2'h2;
   localparam logic [1:0]  SEQ_GAP_GO     = 2'h1;
   localparam int unsigned CLK_FREQ_HZ    = 10_000_000;
   localparam int unsigned POWER_UP_DELAY_TIMER_TIME_MS   = 64;
   localparam int unsigned WRITE_TIME_US  = 4000;
   localparam int unsigned POWER_UP_DELAY_TIMER_CYC_DEF   = POWER_UP_DELAY_TIMER_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int unsigned WRITE_CYC_DEF  = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int          TMR_W          = 20;
   typedef logic [TMR_W-1:0] dewc_tmr_t;
   //------------------------------------------------------------
   // Carriers
   //------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;   // Register offset
      logic [7:0] wdata;  // Write data
      logic       wr;     // Write strobe
      logic       rd;     // Read strobe
   } dewc_bus_s;
   typedef struct packed {
      logic por;          // Power-on reset
      logic bor;          // Brown-out reset
      logic master_clear_reset;         // Master-clear reset
      logic wdt;          // Watchdog reset
   } dewc_rst_cause_s;
endpackage

// [src/dewc_cycle_timer.sv]
// Down-counting one-shot timer: busy for exactly the loaded count.
// Assumes a nonzero load value and one core clock.
`timescale 1ns/1ps
module dewc_cycle_timer
#(
   parameter int WIDTH = 20
)
(
   input  wire logic             i_core_clk, // Core clock
   input  wire logic             i_rst,      // Sync reset
   input  wire logic             i_start,    // Start pulse
   input  wire logic [WIDTH-1:0] i_load,     // Cycles to run
   output logic                  o_busy,     // Running
   output logic                  o_done      // End pulse
);
   logic [WIDTH-1:0] cnt_r;                  // Remaining cycles

   //------------------------------------------------------------
   // Count down, pulse done as busy falls
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         cnt_r  <= '0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end
      else if (i_start && !o_busy)
      begin
         cnt_r  <= i_load;
         o_busy <= 1'b1;
         o_done <= 1'b0;
      end
      else if (o_busy && cnt_r <= WIDTH'(1))
      begin
         o_busy <= 1'b0;
         o_done <= 1'b1;
      end
      else
      begin
         cnt_r  <= o_busy ? cnt_r - WIDTH'(1) : cnt_r;
         o_done <= 1'b0;
      end
   end
endmodule // dewc_cycle_timer

// [src/dewc_unlock_seq.sv]
// Detects the timed two-key unlock sequence on the unlock port.
// Assumes key writes arrive as one-cycle strobes with their data.
`timescale 1ns/1ps
module dewc_unlock_seq
(
   input  wire logic       i_core_clk, // Core clock
   input  wire logic       i_rst,      // Sync reset
   input  wire logic       i_key_wr,   // Unlock port write
   input  wire logic [7:0] i_key_data, // Unlock port data
   output logic            o_armed     // Go allowed this cycle
);
   import dewc_pkg::*;
   typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_KEY1 = 2'b01, SEQ_KEY2 = 2'b10} dewc_seq_e;
   dewc_seq_e  state_r;                // Sequence state
   logic [1:0] cnt_r;                  // Cycles since last step

   // Go write is taken only at the exact cycle
   assign o_armed = (state_r == SEQ_KEY2) && (cnt_r == SEQ_GAP_GO) && !i_key_wr;

   //------------------------------------------------------------
   // Step through keys, drop on any timing slip
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         state_r <= SEQ_IDLE;
         cnt_r   <= 2'h0;
      end
      else if (i_key_wr && i_key_data == UNLOCK_KEY1)
      begin
         state_r <= SEQ_KEY1;          // First key restarts
         cnt_r   <= 2'h1;
      end
      else
      begin
         unique case (state_r)
            SEQ_IDLE:
            begin
               cnt_r <= 2'h0;
            end
            SEQ_KEY1:
            begin
               if (i_key_wr && i_key_data == UNLOCK_KEY2 && cnt_r == SEQ_GAP_KEY)
               begin
                  state_r <= SEQ_KEY2; // Second key on time
                  cnt_r   <= 2'h1;
               end
               else if (i_key_wr || cnt_r == SEQ_GAP_KEY)
               begin
                  state_r <= SEQ_IDLE; // Wrong key, early or late
               end
               else
               begin
                  cnt_r <= cnt_r + 2'h1;
               end
            end
            SEQ_KEY2:
            begin
               if (i_key_wr || cnt_r == SEQ_GAP_GO)
               begin
                  state_r <= SEQ_IDLE; // Window used or missed
               end
               else
               begin
                  cnt_r <= cnt_r + 2'h1;
               end
            end
            default:
            begin
               state_r <= SEQ_IDLE;    // Illegal code
            end
         endcase
      end
   end
endmodule // dewc_unlock_seq

// [src/dewc_top.sv]
// Data EEPROM write controller: registers, unlock check, write timing,
// power-up write lockout and programmer read port.
// Assumes a plain register port with one-cycle strobes and reads
// answered in the next cycle; reset cause is valid during i_rst.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module dewc_top
#(
   parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES  = dewc_pkg::POWER_UP_DELAY_TIMER_CYC_DEF,  // Power-up lockout
   parameter int unsigned WRITE_CYCLES = dewc_pkg::WRITE_CYC_DEF  // Write duration
)
(
   input  wire logic                      i_core_clk,         // Core clock
   input  wire logic                      i_rst,              // Sync reset
   input  wire dewc_pkg::dewc_rst_cause_s i_rst_cause,        // Reset source
   input  wire dewc_pkg::dewc_bus_s       i_bus,              // Register request
   output logic [7:0]                     o_rdata,            // Read data
   input  wire logic                      i_data_protect_fuse,// 0 = protected
   input  wire logic                      i_prog_rd,          // Programmer read
   input  wire logic [7:0]                i_prog_addr,        // Programmer addr
   output logic [7:0]                     o_prog_rdata,       // Programmer data
   output logic                           o_write_busy,       // Write running
   output logic                           o_write_done_flag   // Done flag
);
   import dewc_pkg::*;

   //------------------------------------------------------------
   // Storage
   //------------------------------------------------------------
   logic [7:0] mem_r [0:MEM_DEPTH-1]; // Array
   logic [7:0] irq_ctrl_r;            // Interrupt control
   logic [7:0] peri_ien_r;            // Interrupt enables
   logic [7:0] byte_buf_r;            // Byte buffer
   logic [7:0] loc_sel_r;             // Location select
   logic       done_flag_r;           // Write done
   logic       abort_r;               // Write abort
   logic       permit_r;              // Write permit
   logic       go_r;                  // Write running
   logic       rd_go_r;               // Read pending
   logic [7:0] wr_addr_r;             // Latched location
   logic [7:0] wr_data_r;             // Latched byte
   logic       power_up_delay_timer_pend_r;           // Lockout pending

   //------------------------------------------------------------
   // Decode
   //------------------------------------------------------------
   logic ctl_wr;                      // Control write
   logic flag_wr;                     // Flag write
   logic key_wr;                      // Unlock write
   logic armed;                       // Sequence complete
   logic power_up_delay_timer_busy;                   // Lockout timer
   logic power_up_delay_timer_block;                  // Writes locked out
   logic wt_done;                     // Write timer end
   logic go_nxt;                      // Start a write
   logic [7:0] rdata_nxt;             // Read mux

   assign ctl_wr  = i_bus.wr && i_bus.addr == REG_NVM_CTRL;
   assign flag_wr = i_bus.wr && i_bus.addr == REG_PERI_FLAG;
   assign key_wr  = i_bus.wr && i_bus.addr == REG_UNLOCK;
   assign power_up_delay_timer_block = power_up_delay_timer_pend_r || power_up_delay_timer_busy;

   // Start needs keys, permit, no lockout, idle
   assign go_nxt = ctl_wr && i_bus.wdata[CTL_GO_BIT] && armed
                   && permit_r
                   && !power_up_delay_timer_block
                   && !go_r;

   //------------------------------------------------------------
   // Unlock sequence detector
   //------------------------------------------------------------
   dewc_unlock_seq u_seq
   (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_key_wr   (key_wr),
      .i_key_data (i_bus.wdata),
      .o_armed    (armed)
   );

   //------------------------------------------------------------
   // Power-up lockout timer
   //------------------------------------------------------------
   dewc_cycle_timer #(.WIDTH(TMR_W)) u_power_up_delay_timer
   (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_start    (power_up_delay_timer_pend_r),
      .i_load     (dewc_tmr_t'(POWER_UP_DELAY_TIMER_CYCLES)),
      .o_busy     (power_up_delay_timer_busy),
      .o_done     ()
   );

   //------------------------------------------------------------
   // Write duration timer
   //------------------------------------------------------------
   dewc_cycle_timer #(.WIDTH(TMR_W)) u_wtmr
   (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_start    (go_nxt),
      .i_load     (dewc_tmr_t'(WRITE_CYCLES)),
      .o_busy     (),
      .o_done     (wt_done)
   );

   //------------------------------------------------------------
   // Lockout request caught at power-up resets
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         power_up_delay_timer_pend_r <= power_up_delay_timer_pend_r || i_rst_cause.por || i_rst_cause.bor;
      end
      else
      begin
         power_up_delay_timer_pend_r <= 1'b0;                // Timer now running
      end
   end

   //------------------------------------------------------------
   // Plain software registers
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         irq_ctrl_r <= RST_BYTE;
         peri_ien_r <= RST_BYTE;
         loc_sel_r  <= RST_BYTE;
      end
      else if (i_bus.wr)
      begin
         if (i_bus.addr == REG_IRQ_CTRL)
         begin
            irq_ctrl_r <= i_bus.wdata;
         end
         if (i_bus.addr == REG_PERI_IEN)
         begin
            peri_ien_r <= i_bus.wdata;
         end
         if (i_bus.addr == REG_LOC_SEL)
         begin
            loc_sel_r <= i_bus.wdata;
         end
      end
   end

   //------------------------------------------------------------
   // Byte buffer: software write or array read
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         byte_buf_r <= RST_BYTE;
      end
      else if (i_bus.wr && i_bus.addr == REG_BYTE_BUF)
      begin
         byte_buf_r <= i_bus.wdata;          // Software wins
      end
      else if (rd_go_r)
      begin
         byte_buf_r <= mem_r[loc_sel_r];     // Protection ignored
      end
   end

   //------------------------------------------------------------
   // Permit bit: software only
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         permit_r <= 1'b0;
      end
      else if (ctl_wr)
      begin
         permit_r <= i_bus.wdata[CTL_PERMIT_BIT]; // No hardware clear
      end
   end

   //------------------------------------------------------------
   // Go bit: set-only, held until timer ends
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         go_r      <= 1'b0;
         wr_addr_r <= RST_BYTE;
         wr_data_r <= RST_BYTE;
      end
      else if (go_nxt)
      begin
         go_r      <= 1'b1;
         wr_addr_r <= loc_sel_r;
         wr_data_r <= byte_buf_r;
      end
      else if (wt_done)
      begin
         go_r <= 1'b0;                       // Permit not consulted
      end
   end

   //------------------------------------------------------------
   // Read bit: set-only, one cycle
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         rd_go_r <= 1'b0;
      end
      else
      begin
         rd_go_r <= ctl_wr && i_bus.wdata[CTL_RD_BIT] && !go_r && !rd_go_r;
      end
   end

   //------------------------------------------------------------
   // Abort flag: set by master-clear, watchdog or brown-out reset during write
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         if (go_r && (i_rst_cause.master_clear_reset || i_rst_cause.wdt || i_rst_cause.bor))
         begin
            abort_r <= 1'b1;
         end
         else if (i_rst_cause.por)
         begin
            abort_r <= 1'b0;
         end
      end
      else if (ctl_wr)
      begin
         abort_r <= i_bus.wdata[CTL_ABORT_BIT];
      end
   end

   //------------------------------------------------------------
   // Done flag: set wins over clear
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         done_flag_r <= 1'b0;
      end
      else if (wt_done)
      begin
         done_flag_r <= 1'b1;
      end
      else if (flag_wr)
      begin
         done_flag_r <= i_bus.wdata[FLAG_DONE_BIT]; // Software clear only
      end
   end

   //------------------------------------------------------------
   // Array: erase at start, program at end
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (go_nxt)
      begin
         mem_r[loc_sel_r] <= ERASED_BYTE;
      end
      else if (wt_done)
      begin
         mem_r[wr_addr_r] <= wr_data_r;
      end
   end

   //------------------------------------------------------------
   // Read mux; unlock port has no storage
   //------------------------------------------------------------
   always_comb
   begin
      rdata_nxt = 8'h00;
      unique case (i_bus.addr)
         REG_IRQ_CTRL:  rdata_nxt = irq_ctrl_r;
         REG_PERI_FLAG: rdata_nxt = {done_flag_r, 7'h00};
         REG_PERI_IEN:  rdata_nxt = peri_ien_r;
         REG_BYTE_BUF:  rdata_nxt = byte_buf_r;
         REG_LOC_SEL:   rdata_nxt = loc_sel_r;
         REG_NVM_CTRL:  rdata_nxt = {4'h0, abort_r, permit_r, go_r, rd_go_r};
         REG_UNLOCK:    rdata_nxt = 8'h00;
         default:       rdata_nxt = 8'h00;   // Unmapped
      endcase
   end

   //------------------------------------------------------------
   // Registered outputs
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         o_rdata           <= 8'h00;
         o_prog_rdata      <= 8'h00;
         o_write_busy      <= 1'b0;
         o_write_done_flag <= 1'b0;
      end
      else
      begin
         o_rdata           <= i_bus.rd ? rdata_nxt : 8'h00;
         o_write_busy      <= go_nxt || (go_r && !wt_done);
         o_write_done_flag <= wt_done || (flag_wr ? i_bus.wdata[FLAG_DONE_BIT] : done_flag_r);
         if (i_prog_rd && i_data_protect_fuse)
         begin
            o_prog_rdata <= mem_r[i_prog_addr];
         end
         else
         begin
            o_prog_rdata <= 8'h00;           // Protected reads zero
         end
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   AST_GO_NEEDS_PERMIT: assert property ($rose(go_r) |-> $past(permit_r))
      else $error("write started without permit");
   AST_GO_NEEDS_KEYS: assert property ($rose(go_r) |-> $past(armed) && $past(ctl_wr))
      else $error("write started without unlock sequence");
   AST_PERMIT_SW_ONLY: assert property ((permit_r != $past(permit_r)) |-> $past(ctl_wr))
      else $error("permit changed without software write");
   AST_DONE_SETS_FLAG: assert property (wt_done |=> done_flag_r && !go_r && o_write_done_flag)
      else $error("completion did not set flag and clear go");
   AST_FLAG_STICKY: assert property (done_flag_r && !flag_wr |=> done_flag_r)
      else $error("done flag cleared by hardware");
   AST_POWER_UP_DELAY_TIMER_BLOCKS: assert property (power_up_delay_timer_block && !go_r |=> !go_r)
      else $error("write started during power-up lockout");
   AST_RESET_ZERO: assert property ($fell(i_rst) |-> !permit_r && loc_sel_r == 8'h00 && byte_buf_r == 8'h00)
      else $error("registers not cleared by reset");
   AST_UNLOCK_READS_ZERO: assert property (i_bus.rd && i_bus.addr == REG_UNLOCK |=> o_rdata == 8'h00)
      else $error("unlock port read not zero");
   AST_GO_HELD: assert property ($rose(go_r) |-> go_r[*8])
      else $error("write ended too early");
   AST_ERASE_FIRST: assert property ($rose(go_r) |-> mem_r[wr_addr_r] == ERASED_BYTE)
      else $error("location not erased at write start");
   AST_PROG_ZERO: assert property (!i_data_protect_fuse |=> o_prog_rdata == 8'h00)
      else $error("protected array visible to programmer");
   AST_BUSY_MIRRORS_GO: assert property (o_write_busy == go_r)
      else $error("busy output differs from go bit");

   COV_WRITE_DONE: cover property (wt_done ##1 done_flag_r && !go_r);
   COV_READ: cover property (rd_go_r ##1 i_bus.rd && i_bus.addr == REG_BYTE_BUF);
   COV_REFUSED: cover property (ctl_wr && i_bus.wdata[CTL_GO_BIT] && !armed);
endmodule // dewc_top

// [tb/tb_top.sv]
// Self-checking bench for the data EEPROM write controller.
// Assumes dewc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module tb_top;
   import dewc_pkg::*;
   //------------------------------------------------------------
   // Signals and bench state
   //------------------------------------------------------------
   localparam int PW = 30;                 // Short lockout
   localparam int WC = 16;                 // Short write time
   logic            clk;                   // Core clock
   logic            rst;                   // Sync reset
   dewc_rst_cause_s cause;                 // Reset source
   dewc_bus_s       bus;                   // Register request
   logic [7:0]      rdata, prdata, paddr;  // Read paths
   logic            fuse, prd, busy, done; // Other pins
   int              bad_count, num_checks, t0;
   int              cyc = 0;               // Timeout count
   logic [31:0]     seed = 32'h79E1FC8D;   // Random state
   logic [7:0]      a, d;                  // Target location, byte
   logic [7:0]      em [int];              // Array model
   logic [7:0]      regs [7] = '{REG_IRQ_CTRL, REG_PERI_FLAG, REG_PERI_IEN, REG_BYTE_BUF,
                                 REG_LOC_SEL, REG_NVM_CTRL, REG_UNLOCK};
   dewc_top #(.POWER_UP_DELAY_TIMER_CYCLES(PW), .WRITE_CYCLES(WC)) i_dut (.i_core_clk(clk), .i_rst(rst),
      .i_rst_cause(cause), .i_bus(bus), .o_rdata(rdata), .i_data_protect_fuse(fuse), .i_prog_rd(prd),
      .i_prog_addr(paddr), .o_prog_rdata(prdata), .o_write_busy(busy), .o_write_done_flag(done));
   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One bus cycle, launched on the next rising edge
   task automatic acc(input logic [7:0] ad, input logic [7:0] wd, input logic w, input logic r);
      @(posedge clk);
      bus <= '{ad, wd, w, r};
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      acc(ad, 8'h00, 1'b0, 1'b1);
      acc(8'h00, 8'h00, 1'b0, 1'b0);
      #1 chk(rdata, e);
   endtask
   // Two keys then the go write; gap 1 is the exact spacing, nothing interleaves
   task automatic unl(input int gap, input logic [7:0] cv);
      acc(REG_UNLOCK, UNLOCK_KEY1, 1'b1, 1'b0);
      repeat (gap) acc(8'h00, 8'h00, 1'b0, 1'b0);
      acc(REG_UNLOCK, UNLOCK_KEY2, 1'b1, 1'b0);
      acc(REG_NVM_CTRL, cv, 1'b1, 1'b0);
      acc(8'h00, 8'h00, 1'b0, 1'b0);
   endtask
   task automatic wt(input logic v);
      #1;
      repeat (200)
      begin
         if (busy === v) break;
         @(posedge clk);
         #1;
      end
   endtask
   task automatic nob();
      repeat (3) @(posedge clk);
      #1 chk({7'h00, busy}, 8'h00);
   endtask
   task automatic conclude();
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   //------------------------------------------------------------
   // Clock and timeout
   //------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         bad_count++;
         conclude();
      end
   end
   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial
   begin
      bus = '0;
      rst = 1'b1;
      cause = 4'h8;
      fuse = 1'b1;
      prd = 1'b0;
      paddr = 8'h00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      foreach (regs[i]) rd(regs[i], RST_BYTE);
      acc(REG_NVM_CTRL, 8'h04, 1'b1, 1'b0);
      unl(1, 8'h06);
      nob();
      repeat (PW) @(posedge clk);
      acc(REG_NVM_CTRL, 8'h00, 1'b1, 1'b0);
      unl(1, 8'h06);
      nob();
      acc(REG_NVM_CTRL, 8'h04, 1'b1, 1'b0);
      unl(2, 8'h06);
      nob();
      for (int i = 0; i < 2; i++)
      begin
         a = 8'(rnd());
         d = 8'(rnd());
         acc(REG_PERI_FLAG, 8'h00, 1'b1, 1'b0);
         fuse <= (i == 0);
         acc(REG_LOC_SEL, a, 1'b1, 1'b0);
         acc(REG_BYTE_BUF, d, 1'b1, 1'b0);
         acc(REG_NVM_CTRL, 8'h04, 1'b1, 1'b0);
         unl(1, 8'h06);
         wt(1'b1);
         t0 = $time;
         chk({7'h00, done}, 8'h00);
         if (i == 0) acc(REG_NVM_CTRL, 8'h00, 1'b1, 1'b0);
         acc(8'h00, 8'h00, 1'b0, 1'b0);
         wt(1'b0);
         em[a] = d;
         chk(8'(($time - t0) / 100), 8'(WC + 1));
         chk({7'h00, done}, 8'h01);
         rd(REG_NVM_CTRL, (i == 1) ? 8'h04 : 8'h00);
         repeat (5) @(posedge clk);
         rd(REG_PERI_FLAG, 8'h80);
         acc(REG_BYTE_BUF, 8'h00, 1'b1, 1'b0);
         acc(REG_NVM_CTRL, (i == 1) ? 8'h05 : 8'h01, 1'b1, 1'b0);
         acc(8'h00, 8'h00, 1'b0, 1'b0);
         rd(REG_BYTE_BUF, em[a]);
         @(posedge clk);
         paddr <= a;
         prd <= 1'b1;
         @(posedge clk);
         prd <= 1'b0;
         #1 chk(prdata, (i == 1) ? 8'h00 : em[a]);
      end
      acc(REG_NVM_CTRL, 8'h04, 1'b1, 1'b0);
      unl(1, 8'h06);
      wt(1'b1);
      @(posedge clk);
      rst <= 1'b1;
      cause <= 4'h2;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(REG_NVM_CTRL, 8'h08);
      conclude();
   end
endmodule // tb_top
